// ===== hdl/eqwa_egress_queue.sv
// Purpose: egress packet queue with watermark admission and weighted multicast/unicast choice
// Assumes: one packet descriptor per fabric transfer; link partner acks or retries sent packets
// Notes: registers over AXI4-Lite; ce low freezes every flip-flop outside reset and blocks every handshake except B and R, as bvalid and rvalid hold
`timescale 1ns/1ps
`default_nettype none

// Function
// - weight 0 sends no favoured packet while the other type has one
// - weight 1 alternates types, weight 15 sends fifteen favoured per other
// - no fairness protection; a saturating type may starve the other
// - queue holds at most eight whole packets, kept until acknowledged
// - full queue is signalled to ingress ports, which then hold their packets
// - priority 3 admitted whenever one buffer is free
// - priorities 0-2 admitted only when free count exceeds their threshold
// - thresholds reset to 1, 2 and 3 for priorities 2, 1 and 0
// - queued packets leave in arrival order except during retransmission
// - after a retry send oldest packet of the highest priority present
// - powered down port flushes queue and silently discards accepted packets
// - at most one packet accepted per cycle; losers keep theirs and retry
// - select bit 0 favours multicast, 1 favours unicast; weight counts favoured
// - favoured counter reaching weight gives the other type a turn and clears
// - substitute grant when a type is absent does not consume its turn
module eqwa_egress_queue (
    input wire logic aclk,                      // system clock
    input wire logic aresetn,                   // synchronous reset, active low
    input wire logic ce,                        // clock enable
    input wire logic [7:0] s_axi_awaddr,        // write address
    input wire logic s_axi_awvalid,             // write address valid
    output logic s_axi_awready,                 // write address ready
    input wire logic [31:0] s_axi_wdata,        // write data
    input wire logic [3:0] s_axi_wstrb,         // write byte enables
    input wire logic s_axi_wvalid,              // write data valid
    output logic s_axi_wready,                  // write data ready
    output logic [1:0] s_axi_bresp,             // write response
    output logic s_axi_bvalid,                  // write response valid
    input wire logic s_axi_bready,              // write response ready
    input wire logic [7:0] s_axi_araddr,        // read address
    input wire logic s_axi_arvalid,             // read address valid
    output logic s_axi_arready,                 // read address ready
    output logic [31:0] s_axi_rdata,            // read data
    output logic [1:0] s_axi_rresp,             // read response
    output logic s_axi_rvalid,                  // read data valid
    input wire logic s_axi_rready,              // read data ready
    input wire logic uc_valid,                  // fabric offers a unicast packet
    input wire eqwa_pkg::eqwa_pkt_s uc_pkt,     // offered unicast packet
    output logic uc_ready,                      // unicast packet taken
    input wire logic mc_valid,                  // fabric offers a multicast packet
    input wire eqwa_pkg::eqwa_pkt_s mc_pkt,     // offered multicast packet
    output logic mc_ready,                      // multicast packet taken
    output logic egress_full,                   // queue full, ingress must hold
    output logic tx_valid,                      // packet offered to link
    output eqwa_pkg::eqwa_pkt_s tx_pkt,         // packet offered to link
    input wire logic tx_ready,                  // link takes the packet
    input wire logic link_ack,                  // oldest sent packet acknowledged
    input wire logic link_retry                 // partner retried, resend all unacked
);
    eqwa_pkg::eqwa_entry_s q [eqwa_pkg::DEPTH];
    eqwa_pkg::eqwa_entry_s next_q [eqwa_pkg::DEPTH];
    logic [3:0] occ, next_occ;
    eqwa_pkg::eqwa_mode_e mode, next_mode;
    logic [3:0] cnt [4];
    logic [3:0] next_cnt [4];
    logic [3:0] rr_mc, next_rr_mc;
    logic [31:0] ctrl_w, next_ctrl_w, thr_w, next_thr_w;
    logic bvalid, next_bvalid, rvalid, next_rvalid;
    logic [1:0] bresp, next_bresp, rresp, next_rresp;
    logic [31:0] rdata, next_rdata;

    logic wen, fuc, pd;
    logic [3:0] weight, free, status_occ;
    logic uc_ok, mc_ok, g_uc, g_mc;
    logic [7:0] sent_m, unsent_m, top_m;
    logic [2:0] txi, ri;
    logic [1:0] maxp;
    eqwa_pkg::eqwa_pkt_s g_pkt;

    function automatic logic [2:0] first_set(input logic [7:0] m);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (m[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic admit(input eqwa_pkg::eqwa_pkt_s p, input logic [3:0] fr,
                                   input logic [31:0] thr, input logic down);
        logic ok;
        ok = 1'b0;
        if (down) begin
            ok = 1'b1;
        end else if (p.prio == eqwa_pkg::TOP_PRIO) begin
            ok = (fr != 4'h0);
        end else begin
            unique case (p.prio)
                2'h0: ok = fr > thr[eqwa_pkg::THR_P0_LSB +: 4];
                2'h1: ok = fr > thr[eqwa_pkg::THR_P1_LSB +: 4];
                default: ok = fr > thr[eqwa_pkg::THR_P2_LSB +: 4];
            endcase
        end
        return ok;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be, input logic [31:0] mask);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r & mask;
    endfunction

    assign wen = ctrl_w[eqwa_pkg::CTRL_WEN_BIT];
    assign fuc = ctrl_w[eqwa_pkg::CTRL_FUC_BIT];
    assign weight = ctrl_w[eqwa_pkg::CTRL_WEIGHT_LSB +: 4];
    assign pd = ctrl_w[eqwa_pkg::CTRL_PD_BIT];
    assign free = eqwa_pkg::DEPTH_CNT - occ;
    assign status_occ = occ;

    // register slave: write needs address and data together, one response each
    always_comb begin
        next_ctrl_w = ctrl_w;
        next_thr_w = thr_w;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        s_axi_awready = ce && !bvalid && s_axi_awvalid && s_axi_wvalid;
        s_axi_wready = s_axi_awready;
        s_axi_arready = ce && !rvalid;
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_awready) begin
            next_bvalid = 1'b1;
            next_bresp = eqwa_pkg::RESP_OKAY;
            unique case ({s_axi_awaddr[7:2], 2'h0})
                eqwa_pkg::CTRL_OFF: begin
                    next_ctrl_w = merge(ctrl_w, s_axi_wdata, s_axi_wstrb, eqwa_pkg::CTRL_MASK);
                end
                eqwa_pkg::THRESH_OFF: begin
                    next_thr_w = merge(thr_w, s_axi_wdata, s_axi_wstrb, eqwa_pkg::THR_MASK);
                end
                eqwa_pkg::STATUS_OFF: begin
                    next_bresp = eqwa_pkg::RESP_OKAY;
                end
                default: begin
                    next_bresp = eqwa_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arready && s_axi_arvalid) begin
            next_rvalid = 1'b1;
            next_rresp = eqwa_pkg::RESP_OKAY;
            next_rdata = 32'h0000_0000;
            unique case ({s_axi_araddr[7:2], 2'h0})
                eqwa_pkg::CTRL_OFF: next_rdata = ctrl_w;
                eqwa_pkg::THRESH_OFF: next_rdata = thr_w;
                eqwa_pkg::STATUS_OFF: begin
                    next_rdata[eqwa_pkg::STAT_OCC_LSB +: 4] = status_occ;
                    next_rdata[eqwa_pkg::STAT_FREE_LSB +: 4] = free;
                    next_rdata[eqwa_pkg::STAT_FULL_BIT] = egress_full;
                end
                default: next_rresp = eqwa_pkg::RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_w <= eqwa_pkg::CTRL_RST;
            thr_w <= eqwa_pkg::THR_RST;
            bvalid <= 1'b0;
            bresp <= eqwa_pkg::RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= eqwa_pkg::RESP_OKAY;
            rdata <= 32'h0000_0000;
        end else if (ce) begin
            ctrl_w <= next_ctrl_w;
            thr_w <= next_thr_w;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
        end
    end

    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rresp = rresp;
    assign s_axi_rdata = rdata;

    // admission, one grant per cycle, queue update and link side
    always_comb begin
        for (int i = 0; i < eqwa_pkg::DEPTH; i++) begin
            next_q[i] = q[i];
        end
        for (int p = 0; p < 4; p++) begin
            next_cnt[p] = cnt[p];
        end
        next_occ = occ;
        next_mode = mode;
        next_rr_mc = rr_mc;
        g_uc = 1'b0;
        g_mc = 1'b0;
        uc_ok = uc_valid && admit(uc_pkt, free, thr_w, pd);
        mc_ok = mc_valid && admit(mc_pkt, free, thr_w, pd);
        if (uc_ok && mc_ok && uc_pkt.prio != mc_pkt.prio) begin
            g_uc = uc_pkt.prio > mc_pkt.prio;
            g_mc = !g_uc;
        end else if (uc_ok && mc_ok && !wen) begin
            g_uc = rr_mc[uc_pkt.prio];
            g_mc = !g_uc;
            next_rr_mc[uc_pkt.prio] = g_mc;
        end else if (uc_ok && mc_ok) begin
            // favoured turn while counter is below weight; no hidden fairness
            if (cnt[uc_pkt.prio] < weight) begin
                g_uc = fuc;
                g_mc = !fuc;
                next_cnt[uc_pkt.prio] = cnt[uc_pkt.prio] + 4'h1;
            end else begin
                g_uc = !fuc;
                g_mc = fuc;
                next_cnt[uc_pkt.prio] = 4'h0;
            end
        end else begin
            // a lone type takes the slot without touching the counter
            g_uc = uc_ok;
            g_mc = mc_ok && !uc_ok;
        end
        uc_ready = ce && g_uc;
        mc_ready = ce && g_mc;
        g_pkt = g_uc ? uc_pkt : mc_pkt;

        maxp = 2'h0;
        for (int i = 0; i < eqwa_pkg::DEPTH; i++) begin
            sent_m[i] = (4'(i) < occ) && q[i].sent;
            unsent_m[i] = (4'(i) < occ) && !q[i].sent;
            if (unsent_m[i] && q[i].pkt.prio > maxp) begin
                maxp = q[i].pkt.prio;
            end
        end
        for (int i = 0; i < eqwa_pkg::DEPTH; i++) begin
            top_m[i] = unsent_m[i] && (q[i].pkt.prio == maxp);
        end
        unique case (mode)
            eqwa_pkg::EQWA_FCFS: txi = first_set(unsent_m);
            eqwa_pkg::EQWA_RETRY: txi = first_set(top_m);
        endcase
        tx_valid = ce && !pd && (|unsent_m);
        tx_pkt = q[txi].pkt;
        ri = first_set(sent_m);

        if (tx_valid && tx_ready) begin
            next_q[txi].sent = 1'b1;
            next_mode = eqwa_pkg::EQWA_FCFS;
        end
        if (ce && link_ack && (|sent_m)) begin
            // retire the oldest sent packet, keeping arrival order
            for (int i = 0; i < eqwa_pkg::DEPTH - 1; i++) begin
                if (3'(i) >= ri) begin
                    next_q[i] = next_q[i + 1];
                end
            end
            next_q[eqwa_pkg::DEPTH - 1] = '0;
            next_occ = next_occ - 4'h1;
        end
        if (ce && link_retry) begin
            for (int i = 0; i < eqwa_pkg::DEPTH; i++) begin
                next_q[i].sent = 1'b0;
            end
            next_mode = eqwa_pkg::EQWA_RETRY;
        end
        if ((g_uc || g_mc) && !pd) begin
            next_q[next_occ[2:0]].pkt = g_pkt;
            next_q[next_occ[2:0]].sent = 1'b0;
            next_occ = next_occ + 4'h1;
        end
        if (pd) begin
            // flushed and grants still accepted, but nothing is stored
            for (int i = 0; i < eqwa_pkg::DEPTH; i++) begin
                next_q[i] = '0;
            end
            next_occ = 4'h0;
            next_mode = eqwa_pkg::EQWA_FCFS;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < eqwa_pkg::DEPTH; i++) begin
                q[i] <= '0;
            end
            for (int p = 0; p < 4; p++) begin
                cnt[p] <= 4'h0;
            end
            occ <= 4'h0;
            mode <= eqwa_pkg::EQWA_FCFS;
            rr_mc <= 4'h0;
        end else if (ce) begin
            for (int i = 0; i < eqwa_pkg::DEPTH; i++) begin
                q[i] <= next_q[i];
            end
            for (int p = 0; p < 4; p++) begin
                cnt[p] <= next_cnt[p];
            end
            occ <= next_occ;
            mode <= next_mode;
            rr_mc <= next_rr_mc;
        end
    end

    assign egress_full = (occ == eqwa_pkg::DEPTH_CNT) && !pd;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_both_same_prio;
        uc_ok && mc_ok && uc_pkt.prio == mc_pkt.prio && wen;
    endsequence

    sequence s_retry_then_send;
        ce && link_retry && !pd ##1 (!link_retry && tx_valid)[*1];
    endsequence

    a_single_grant: assert property (!(uc_ready && mc_ready))
        else $error("two packets accepted in one cycle");
    a_full_holds: assert property (egress_full |-> !uc_ready && !mc_ready)
        else $error("packet accepted while queue full");
    a_top_prio_admit: assert property (
        ce && mc_valid && !uc_valid && mc_pkt.prio == 2'h3 && free != 4'h0 |-> mc_ready)
        else $error("priority 3 refused with a free buffer");
    a_watermark_check: assert property (
        uc_ready && !pd && uc_pkt.prio == 2'h1 |-> free > thr_w[eqwa_pkg::THR_P1_LSB +: 4])
        else $error("priority 1 admitted at or below threshold");
    a_reset_thresholds: assert property (
        $past(!aresetn) |-> thr_w == 32'h0001_0203)
        else $error("thresholds not at defaults after reset");
    a_weight_zero: assert property (
        s_both_same_prio and (ce && weight == 4'h0) |-> (fuc ? mc_ready : uc_ready))
        else $error("favoured type sent with weight zero");
    a_counter_clear: assert property (
        s_both_same_prio and (ce && cnt[uc_pkt.prio] >= weight) |=> cnt[$past(uc_pkt.prio)] == 4'h0)
        else $error("favoured counter not cleared after other type");
    a_flush_down: assert property (ce && pd |=> occ == 4'h0)
        else $error("queue not flushed while powered down");
    a_free_track: assert property (
        ce && !pd && (uc_ready || mc_ready) && !link_ack |=> free == $past(free) - 4'h1)
        else $error("free count not updated on admit");
    a_retry_highest: assert property (
        s_retry_then_send |-> tx_pkt.prio == maxp && txi == first_set(top_m))
        else $error("retry did not pick highest priority packet");
    a_fcfs_order: assert property (
        tx_valid && mode == eqwa_pkg::EQWA_FCFS |-> txi == first_set(unsent_m)
            && !q[txi].sent)
        else $error("packet sent out of arrival order");
endmodule // eqwa_egress_queue

`default_nettype wire

// ===== hdl/eqwa_pkg.sv
// Purpose: shared constants and types for the egress queue with watermark admission
// Assumes: 32-bit AXI4-Lite register words, eight-packet egress queue
// Notes: every offset, field position and reset value lives here once
package eqwa_pkg;
    localparam int DEPTH = 8;
    localparam logic [3:0] DEPTH_CNT = 4'h8;

    // register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] THRESH_OFF = 8'h04;
    localparam logic [7:0] STATUS_OFF = 8'h08;

    // control word fields
    localparam int CTRL_WEN_BIT = 0;
    localparam int CTRL_FUC_BIT = 1;
    localparam int CTRL_WEIGHT_LSB = 4;
    localparam int CTRL_PD_BIT = 8;
    localparam logic [31:0] CTRL_MASK = 32'h0000_01f3;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // threshold word fields, defaults 3 / 2 / 1
    localparam int THR_P0_LSB = 0;
    localparam int THR_P1_LSB = 8;
    localparam int THR_P2_LSB = 16;
    localparam logic [31:0] THR_MASK = 32'h000f_0f0f;
    localparam logic [31:0] THR_RST = 32'h0001_0203;

    // status word fields
    localparam int STAT_OCC_LSB = 0;
    localparam int STAT_FREE_LSB = 8;
    localparam int STAT_FULL_BIT = 16;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] TOP_PRIO = 2'h3;

    typedef struct packed {
        logic [1:0] prio;
        logic [29:0] body;
    } eqwa_pkt_s;

    typedef struct packed {
        eqwa_pkt_s pkt;
        logic sent;
    } eqwa_entry_s;

    typedef enum logic [0:0] {
        EQWA_FCFS = 1'b0,
        EQWA_RETRY = 1'b1
    } eqwa_mode_e;
endpackage

// ===== testbench/eqwa_link_model.sv
// Purpose: link partner model that takes, acknowledges and retries egress packets
// Assumes: the bench steers it through take_en, auto_ack and retry_req
// Notes: every packet taken is logged in sent_log for order checks
`timescale 1ns/1ps
`default_nettype none
module eqwa_link_model (
    input wire logic aclk,                  // system clock
    input wire logic aresetn,               // synchronous reset, active low
    input wire logic tx_valid,              // packet offered
    input wire eqwa_pkg::eqwa_pkt_s tx_pkt, // offered packet
    output logic tx_ready,                  // model takes the packet
    output logic link_ack,                  // oldest sent packet acknowledged
    output logic link_retry,                // resend all unacknowledged
    input wire logic take_en,               // bench lets the model take packets
    input wire logic auto_ack,              // acknowledge every sent packet
    input wire logic retry_req              // bench asks for a retry
);
    eqwa_pkg::eqwa_pkt_s sent_log[$];
    int pend;
    int sent;
    logic fire;
    always @(posedge aclk) begin
        sent = (tx_valid === 1'b1 && tx_ready === 1'b1) ? 1 : 0;
        // never acknowledge more than was sent, nor across a retry
        fire = auto_ack && !retry_req && (pend + sent) > 0;
        if (!aresetn) begin
            tx_ready <= 1'b0;
            link_ack <= 1'b0;
            link_retry <= 1'b0;
            pend <= 0;
        end else begin
            if (sent == 1) begin
                sent_log.push_back(tx_pkt);
            end
            tx_ready <= take_en;
            link_ack <= fire;
            link_retry <= retry_req;
            pend <= retry_req ? 0 : pend + sent - (fire ? 1 : 0);
        end
    end
endmodule // eqwa_link_model
`default_nettype wire

// ===== testbench/tb_egress_queue_watermark_admission.sv
// Purpose: self-checking bench for the egress queue with watermark admission
// Assumes: registers at the package offsets, link partner model on the link side
// Notes: inputs change by non-blocking assignment at rising edges
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
    $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module tb_egress_queue_watermark_admission;
    logic aclk, aresetn, ce;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic uc_valid, uc_ready, mc_valid, mc_ready, egress_full, tx_valid, tx_ready;
    eqwa_pkg::eqwa_pkt_s uc_pkt, mc_pkt, tx_pkt;
    logic link_ack, link_retry, take_en, auto_ack, retry_req;
    int err_count, checks_done;
    int exp_q[$];

    eqwa_egress_queue dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .uc_valid(uc_valid),
        .uc_pkt(uc_pkt), .uc_ready(uc_ready), .mc_valid(mc_valid), .mc_pkt(mc_pkt),
        .mc_ready(mc_ready), .egress_full(egress_full), .tx_valid(tx_valid), .tx_pkt(tx_pkt),
        .tx_ready(tx_ready), .link_ack(link_ack), .link_retry(link_retry));
    eqwa_link_model link (.aclk(aclk), .aresetn(aresetn), .tx_valid(tx_valid), .tx_pkt(tx_pkt),
        .tx_ready(tx_ready), .link_ack(link_ack), .link_retry(link_retry), .take_en(take_en),
        .auto_ack(auto_ack), .retry_req(retry_req));

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    // offer one unicast packet, held until taken or given up after three edges
    task automatic offer(input logic [1:0] p, input int b, output logic got);
        int n;
        uc_pkt <= {p, 30'(b)};
        uc_valid <= 1'b1;
        got = 1'b0;
        n = 0;
        while (!got && n < 3) begin
            @(posedge aclk);
            got = (uc_ready === 1'b1);
            n++;
        end
        uc_valid <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        axi_read(eqwa_pkg::CTRL_OFF, d, r);
        `CHK("ctrl reset", 32'h0000_0000, d)
        axi_read(eqwa_pkg::THRESH_OFF, d, r);
        `CHK("thresh reset", 32'h0001_0203, d)
        axi_write(eqwa_pkg::THRESH_OFF, 32'h0002_0405, r);
        axi_read(eqwa_pkg::THRESH_OFF, d, r);
        `CHK("thresh write", 32'h0002_0405, d)
        axi_write(eqwa_pkg::THRESH_OFF, 32'h0001_0203, r);
        axi_read(8'h0c, d, r);
        `CHK("unmapped resp", 2'h2, r)
        axi_write(eqwa_pkg::STATUS_OFF, 32'hffff_ffff, r);
        axi_read(eqwa_pkg::STATUS_OFF, d, r);
        `CHK("status empty", 32'h0000_0800, d)
        $display("test regs done");
    endtask

    task automatic t_admit();
        logic [1:0] pr[12] = '{0, 0, 0, 0, 0, 0, 1, 1, 2, 2, 3, 3};
        logic [3:0] thr[3] = '{4'h3, 4'h2, 4'h1};
        int free;
        logic got, want;
        logic [31:0] d;
        logic [1:0] r;
        free = 8;
        foreach (pr[i]) begin
            want = (pr[i] == 2'h3) ? (free >= 1) : (free > thr[pr[i]]);
            offer(pr[i], i, got);
            `CHK("admit", want, got)
            if (want) begin
                exp_q.push_back(i);
                free--;
            end
        end
        `CHK("egress full", 1'b1, egress_full)
        axi_read(eqwa_pkg::STATUS_OFF, d, r);
        `CHK("status full", 32'h0001_0008, d)
        $display("test admit done");
    endtask

    task automatic t_send();
        logic [31:0] d;
        logic [1:0] r;
        take_en <= 1'b1;
        while (link.sent_log.size() < 8) @(posedge aclk);
        take_en <= 1'b0;
        foreach (exp_q[i]) `CHK("fcfs order", 30'(exp_q[i]), link.sent_log[i].body)
        retry_req <= 1'b1;
        @(posedge aclk);
        retry_req <= 1'b0;
        repeat (3) @(posedge aclk);
        take_en <= 1'b1;
        while (link.sent_log.size() < 16) @(posedge aclk);
        take_en <= 1'b0;
        `CHK("retry first", 30'(exp_q[7]), link.sent_log[8].body)
        `CHK("after retry", 30'(exp_q[0]), link.sent_log[9].body)
        auto_ack <= 1'b1;
        repeat (12) @(posedge aclk);
        auto_ack <= 1'b0;
        axi_read(eqwa_pkg::STATUS_OFF, d, r);
        `CHK("status drained", 32'h0000_0800, d)
        $display("test send done");
    endtask

    task automatic t_power();
        logic got;
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 3; i++) offer(2'h0, 40 + i, got);
        axi_write(eqwa_pkg::CTRL_OFF, 32'h0000_0100, r);
        `CHK("tx idle when down", 1'b0, tx_valid)
        axi_read(eqwa_pkg::STATUS_OFF, d, r);
        `CHK("flushed", 32'h0000_0800, d)
        for (int i = 0; i < 10; i++) begin
            offer(2'h0, 50 + i, got);
            `CHK("down accept", 1'b1, got)
        end
        axi_read(eqwa_pkg::STATUS_OFF, d, r);
        `CHK("discarded", 32'h0000_0800, d)
        axi_write(eqwa_pkg::CTRL_OFF, 32'h0000_0000, r);
        $display("test power done");
    endtask

    task automatic t_wrr();
        logic [31:0] cfg[5] = '{32'h001, 32'h011, 32'h0f1, 32'h003, 32'h000};
        logic [1:0] r;
        logic exp_mc, alt;
        int cnt;
        foreach (cfg[k]) begin
            do_reset();
            axi_write(eqwa_pkg::CTRL_OFF, cfg[k], r);
            take_en <= 1'b1;
            auto_ack <= 1'b1;
            uc_pkt <= {eqwa_pkg::TOP_PRIO, 30'h1};
            mc_pkt <= {eqwa_pkg::TOP_PRIO, 30'h2};
            uc_valid <= 1'b1;
            mc_valid <= 1'b1;
            cnt = 0;
            alt = 1'b1;
            repeat (40) begin
                @(posedge aclk);
                `CHK("one grant", 1'b0, uc_ready & mc_ready)
                if (uc_ready === 1'b1 || mc_ready === 1'b1) begin
                    if (!cfg[k][0]) begin
                        exp_mc = alt;
                        alt = !alt;
                    end else if (cnt < cfg[k][7:4]) begin
                        exp_mc = !cfg[k][1];
                        cnt++;
                    end else begin
                        exp_mc = cfg[k][1];
                        cnt = 0;
                    end
                    `CHK("grant type", exp_mc, mc_ready)
                end
            end
            uc_valid <= 1'b0;
            mc_valid <= 1'b0;
            take_en <= 1'b0;
            auto_ack <= 1'b0;
            @(posedge aclk);
        end
        $display("test wrr done");
    endtask

    initial begin
        {ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {uc_valid, mc_valid, take_en, auto_ack, retry_req} = 5'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hf;
        uc_pkt = 32'h0000_0000;
        mc_pkt = 32'h0000_0000;
        err_count = 0;
        checks_done = 0;
        do_reset();
        t_regs();
        t_admit();
        t_send();
        t_power();
        t_wrr();
        print_verdict();
    end

    initial begin
        #(25.0 * 20000);
        err_count++;
        print_verdict();
    end
endmodule // tb_egress_queue_watermark_admission
`default_nettype wire
